// >>> hdl/modem_route.sv
// Purpose: modem pin and serial routing, normal and loopback
// Assumes: pins are synchronous to the core clock
// Notes:   all outputs registered
`timescale 1ns/1ns
`default_nettype none
module modem_route (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    input  wire logic i_loop,
    input  wire logic i_dtr,
    input  wire logic i_rts,
    input  wire logic i_ring,
    input  wire logic i_irq_en,
    input  wire logic i_cts_n,
    input  wire logic i_dsr_n,
    input  wire logic i_ri_n,
    input  wire logic i_dcd_n,
    input  wire logic i_tx_serial,
    input  wire logic i_serial_in,
    output var  logic o_serial_out,
    output var  logic o_rx_serial,
    output var  logic o_rts_n,
    output var  logic o_dtr_n,
    output var  logic o_cts,
    output var  logic o_dsr,
    output var  logic o_ri,
    output var  logic o_dcd
);
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_serial_out <= 1'b1;
            o_rx_serial  <= 1'b1;
        end else begin
            o_serial_out <= i_loop | i_tx_serial;
            o_rx_serial  <= i_loop ? i_tx_serial : i_serial_in;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_rts_n <= 1'b1;
            o_dtr_n <= 1'b1;
        end else begin
            o_rts_n <= i_loop | ~i_rts;
            o_dtr_n <= i_loop | ~i_dtr;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_cts <= 1'b0;
            o_dsr <= 1'b0;
            o_ri  <= 1'b0;
            o_dcd <= 1'b0;
        end else if (i_loop) begin
            o_dsr <= i_dtr;
            o_cts <= i_rts;
            o_ri  <= i_ring;
            o_dcd <= i_irq_en;
        end else begin
            o_cts <= ~i_cts_n;
            o_dsr <= ~i_dsr_n;
            o_ri  <= ~i_ri_n;
            o_dcd <= ~i_dcd_n;
        end
    end
endmodule : modem_route
`default_nettype wire

// >>> hdl/sticky_flag.sv
// Purpose: status flag set by hardware, cleared by software
// Assumes: set and clear are single-cycle strobes
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ns
`default_nettype none
module sticky_flag #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_core_clk,
    input  wire logic i_srst,
    input  wire logic i_set,
    input  wire logic i_clr,
    output var  logic o_flag
);
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_flag <= RST_VAL;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule : sticky_flag
`default_nettype wire

// >>> hdl/uart_lsm.sv
// Purpose: uart line status and modem control with AXI4-Lite registers
// Assumes: rx/tx datapath and fifos sit outside and report by strobes and levels
// Notes:   outputs are registered; unmapped accesses answer SLVERR
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module uart_lsm (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_srst,
    // AXI4-Lite slave
    input  wire logic [uart_lsm_pkg::AXI_AW-1:0]   i_s_axi_awaddr,
    input  wire logic                              i_s_axi_awvalid,
    output var  logic                              o_s_axi_awready,
    input  wire logic [uart_lsm_pkg::AXI_DW-1:0]   i_s_axi_wdata,
    input  wire logic [3:0]                        i_s_axi_wstrb,
    input  wire logic                              i_s_axi_wvalid,
    output var  logic                              o_s_axi_wready,
    output var  logic [1:0]                        o_s_axi_bresp,
    output var  logic                              o_s_axi_bvalid,
    input  wire logic                              i_s_axi_bready,
    input  wire logic [uart_lsm_pkg::AXI_AW-1:0]   i_s_axi_araddr,
    input  wire logic                              i_s_axi_arvalid,
    output var  logic                              o_s_axi_arready,
    output var  logic [uart_lsm_pkg::AXI_DW-1:0]   o_s_axi_rdata,
    output var  logic [1:0]                        o_s_axi_rresp,
    output var  logic                              o_s_axi_rvalid,
    input  wire logic                              i_s_axi_rready,
    // receive datapath
    input  wire logic                              i_rx_stat_load,
    input  wire logic                              i_rx_stat_brk,
    input  wire logic                              i_rx_stat_frm,
    input  wire logic                              i_rx_stat_par,
    input  wire logic                              i_rx_overrun,
    input  wire logic                              i_rx_data_avail,
    input  wire logic                              i_rx_err_in_fifo,
    // transmit datapath
    input  wire logic                              i_tx_load,
    input  wire logic                              i_tx_fifo_empty,
    input  wire logic                              i_tx_holding_empty,
    input  wire logic                              i_tx_shift_empty,
    input  wire logic                              i_tx_serial,
    input  wire logic                              i_int_req,
    // line pins
    input  wire logic                              i_serial_in,
    input  wire logic                              i_cts_n,
    input  wire logic                              i_dsr_n,
    input  wire logic                              i_ri_n,
    input  wire logic                              i_dcd_n,
    output var  logic                              o_serial_out,
    output var  logic                              o_rts_n,
    output var  logic                              o_dtr_n,
    // towards datapath and interrupt logic
    output var  logic                              o_rx_serial,
    output var  logic                              o_cts,
    output var  logic                              o_dsr,
    output var  logic                              o_ri,
    output var  logic                              o_dcd,
    output var  logic                              o_fifo_mode,
    output var  logic                              o_tx_wr,
    output var  logic [7:0]                        o_tx_data,
    output var  logic                              o_tx_empty_int,
    output var  logic                              o_irq
);
    import uart_lsm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic                 awready_q;
    logic                 wready_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 arready_q;
    logic                 rvalid_q;
    logic [1:0]           rresp_q;
    logic [AXI_DW-1:0]    rdata_q;
    logic                 aw_held_q;
    logic                 w_held_q;
    logic [AXI_AW-1:0]    waddr_q;
    logic [AXI_DW-1:0]    wdata_q;
    logic                 wstrb0_q;
    logic                 aw_hs;
    logic                 w_hs;
    logic                 ar_hs;
    logic                 wr_fire;
    logic [7:0]           wr_word;
    logic [7:0]           rd_word;
    logic                 lsr_rd;
    logic                 tx_wr;
    logic [AXI_DW-1:0]    rd_data_d;
    logic [1:0]           rd_resp_d;
    logic [MCR_W-1:0]     mcr_q;
    logic                 fifo_en_q;
    logic                 tx_int_en_q;
    logic                 tx_wr_q;
    logic [7:0]           tx_data_q;
    logic                 tx_fifo_empty_q;
    logic                 tx_hold_set;
    logic                 tx_hold_mt;
    logic                 brk_flag;
    logic                 frm_flag;
    logic                 par_flag;
    logic                 ovr_flag;
    logic                 rx_fifo_err_q;
    logic                 tx_idle_q;
    logic                 data_ready_q;
    logic                 tx_empty_int_q;
    logic                 irq_q;
    logic [7:0]           lsr_view;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes and decode

    assign aw_hs   = i_s_axi_awvalid & awready_q;
    assign w_hs    = i_s_axi_wvalid & wready_q;
    assign ar_hs   = i_s_axi_arvalid & arready_q;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_word = {waddr_q[AXI_AW-1:2], 2'b00};
    assign rd_word = {i_s_axi_araddr[AXI_AW-1:2], 2'b00};
    assign lsr_rd  = ar_hs & (rd_word == OFS_LINE_STATUS);
    assign tx_wr   = wr_fire & wstrb0_q & (wr_word == OFS_TX_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // write address and data capture, either order

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            aw_held_q <= 1'b0;
            waddr_q   <= '0;
        end else if (aw_hs) begin
            aw_held_q <= 1'b1;
            waddr_q   <= i_s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            w_held_q <= 1'b0;
            wdata_q  <= '0;
            wstrb0_q <= 1'b0;
        end else if (w_hs) begin
            w_held_q <= 1'b1;
            wdata_q  <= i_s_axi_wdata;
            wstrb0_q <= i_s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            awready_q <= 1'b0;
        end else if (aw_hs) begin
            awready_q <= 1'b0;
        end else if (!aw_held_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            wready_q <= 1'b0;
        end else if (w_hs) begin
            wready_q <= 1'b0;
        end else if (!w_held_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // write response
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            case (wr_word)
                OFS_TX_DATA, OFS_INT_CTRL, OFS_FIFO_CTRL, OFS_MODEM_CTRL: begin
                    bresp_q <= RESP_OKAY;
                end
                default: begin
                    bresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (bvalid_q && i_s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software-written control

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            mcr_q <= MCR_RESET;
        end else if (wr_fire && wstrb0_q && wr_word == OFS_MODEM_CTRL) begin
            mcr_q <= wdata_q[MCR_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            fifo_en_q <= CTRL_BIT_RESET;
        end else if (wr_fire && wstrb0_q && wr_word == OFS_FIFO_CTRL) begin
            fifo_en_q <= wdata_q[FCR_FIFO_EN];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_int_en_q <= CTRL_BIT_RESET;
        end else if (wr_fire && wstrb0_q && wr_word == OFS_INT_CTRL) begin
            tx_int_en_q <= wdata_q[ICR_TX_EMPTY_EN];
        end
    end

    // transmit data strobe to the holding stage or fifo
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_wr_q   <= 1'b0;
            tx_data_q <= '0;
        end else begin
            tx_wr_q <= tx_wr;
            if (tx_wr) begin
                tx_data_q <= wdata_q[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit status

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_fifo_empty_q <= 1'b1;
        end else begin
            tx_fifo_empty_q <= i_tx_fifo_empty;
        end
    end

    // legacy: load into shifter; fifo: fifo turns empty
    assign tx_hold_set = fifo_en_q ? (i_tx_fifo_empty & ~tx_fifo_empty_q)
                                   : i_tx_load;

    sticky_flag #(
        .RST_VAL (LSR_RESET[LSR_TX_HOLD_MT])
    ) u_tx_hold_flag (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_set      (tx_hold_set),
        .i_clr      (tx_wr),
        .o_flag     (tx_hold_mt)
    );

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_idle_q <= LSR_RESET[LSR_TX_IDLE];
        end else begin
            tx_idle_q <= i_tx_shift_empty & (fifo_en_q ? i_tx_fifo_empty : i_tx_holding_empty);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive status

    // the datapath loads these at the rbr or at the fifo head
    sticky_flag #(
        .RST_VAL (LSR_RESET[LSR_BREAK])
    ) u_brk_flag (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_set      (i_rx_stat_load & i_rx_stat_brk),
        .i_clr      (lsr_rd),
        .o_flag     (brk_flag)
    );

    sticky_flag #(
        .RST_VAL (LSR_RESET[LSR_FRAMING])
    ) u_frm_flag (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_set      (i_rx_stat_load & i_rx_stat_frm),
        .i_clr      (lsr_rd),
        .o_flag     (frm_flag)
    );

    sticky_flag #(
        .RST_VAL (LSR_RESET[LSR_PARITY])
    ) u_par_flag (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_set      (i_rx_stat_load & i_rx_stat_par),
        .i_clr      (lsr_rd),
        .o_flag     (par_flag)
    );

    sticky_flag #(
        .RST_VAL (LSR_RESET[LSR_OVERRUN])
    ) u_ovr_flag (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_set      (i_rx_overrun),
        .i_clr      (lsr_rd),
        .o_flag     (ovr_flag)
    );

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rx_fifo_err_q <= LSR_RESET[LSR_RX_FIFO_ERR];
        end else if (!fifo_en_q) begin
            rx_fifo_err_q <= 1'b0;
        end else if (i_rx_err_in_fifo) begin
            rx_fifo_err_q <= 1'b1;
        end else if (lsr_rd) begin
            rx_fifo_err_q <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            data_ready_q <= LSR_RESET[LSR_DATA_READY];
        end else begin
            data_ready_q <= i_rx_data_avail;
        end
    end

    always_comb begin
        lsr_view                  = 8'h00;
        lsr_view[LSR_DATA_READY]  = data_ready_q;
        lsr_view[LSR_OVERRUN]     = ovr_flag;
        lsr_view[LSR_PARITY]      = par_flag;
        lsr_view[LSR_FRAMING]     = frm_flag;
        lsr_view[LSR_BREAK]       = brk_flag;
        lsr_view[LSR_TX_HOLD_MT]  = tx_hold_mt;
        lsr_view[LSR_TX_IDLE]     = tx_idle_q;
        lsr_view[LSR_RX_FIFO_ERR] = rx_fifo_err_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rd_data_d = '0;
        rd_resp_d = RESP_OKAY;
        case (rd_word)
            OFS_TX_DATA: begin
                rd_data_d = '0;
            end
            OFS_INT_CTRL: begin
                rd_data_d[ICR_TX_EMPTY_EN] = tx_int_en_q;
            end
            OFS_FIFO_CTRL: begin
                rd_data_d[FCR_FIFO_EN] = fifo_en_q;
            end
            OFS_MODEM_VIEW: begin
                rd_data_d[3:0] = {o_dcd, o_ri, o_dsr, o_cts};
            end
            OFS_MODEM_CTRL: begin
                rd_data_d[MCR_W-1:0] = mcr_q;
            end
            OFS_LINE_STATUS: begin
                rd_data_d[7:0] = lsr_view;
            end
            default: begin
                rd_resp_d = RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            arready_q <= 1'b0;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data_d;
            rresp_q  <= rd_resp_d;
        end else if (rvalid_q && i_s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt requests

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            tx_empty_int_q <= 1'b0;
            irq_q          <= 1'b0;
        end else begin
            tx_empty_int_q <= tx_int_en_q & tx_hold_mt;
            irq_q          <= mcr_q[MCR_IRQ_EN] & i_int_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modem pins and loopback

    modem_route u_modem_route (
        .i_core_clk   (i_core_clk),
        .i_srst       (i_srst),
        .i_loop       (mcr_q[MCR_LOOP]),
        .i_dtr        (mcr_q[MCR_DTR]),
        .i_rts        (mcr_q[MCR_RTS]),
        .i_ring       (mcr_q[MCR_RING]),
        .i_irq_en     (mcr_q[MCR_IRQ_EN]),
        .i_cts_n      (i_cts_n),
        .i_dsr_n      (i_dsr_n),
        .i_ri_n       (i_ri_n),
        .i_dcd_n      (i_dcd_n),
        .i_tx_serial  (i_tx_serial),
        .i_serial_in  (i_serial_in),
        .o_serial_out (o_serial_out),
        .o_rx_serial  (o_rx_serial),
        .o_rts_n      (o_rts_n),
        .o_dtr_n      (o_dtr_n),
        .o_cts        (o_cts),
        .o_dsr        (o_dsr),
        .o_ri         (o_ri),
        .o_dcd        (o_dcd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_s_axi_awready = awready_q;
    assign o_s_axi_wready  = wready_q;
    assign o_s_axi_bvalid  = bvalid_q;
    assign o_s_axi_bresp   = bresp_q;
    assign o_s_axi_arready = arready_q;
    assign o_s_axi_rvalid  = rvalid_q;
    assign o_s_axi_rdata   = rdata_q;
    assign o_s_axi_rresp   = rresp_q;
    assign o_fifo_mode     = fifo_en_q;
    assign o_tx_wr         = tx_wr_q;
    assign o_tx_data       = tx_data_q;
    assign o_tx_empty_int  = tx_empty_int_q;
    assign o_irq           = irq_q;
endmodule : uart_lsm
`default_nettype wire

// >>> hdl/uart_lsm_pkg.sv
// Purpose: constants for the line status and modem control block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   register offsets are byte addresses
package uart_lsm_pkg;
    localparam int          AXI_AW           = 8;
    localparam int          AXI_DW           = 32;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    localparam logic [7:0]  OFS_TX_DATA      = 8'h00;
    localparam logic [7:0]  OFS_INT_CTRL     = 8'h04;
    localparam logic [7:0]  OFS_FIFO_CTRL    = 8'h08;
    localparam logic [7:0]  OFS_MODEM_VIEW   = 8'h0c;
    localparam logic [7:0]  OFS_MODEM_CTRL   = 8'h10;
    localparam logic [7:0]  OFS_LINE_STATUS  = 8'h14;

    // line_status_reg fields
    localparam int          LSR_DATA_READY   = 0;
    localparam int          LSR_OVERRUN      = 1;
    localparam int          LSR_PARITY       = 2;
    localparam int          LSR_FRAMING      = 3;
    localparam int          LSR_BREAK        = 4;
    localparam int          LSR_TX_HOLD_MT   = 5;
    localparam int          LSR_TX_IDLE      = 6;
    localparam int          LSR_RX_FIFO_ERR  = 7;
    localparam logic [7:0]  LSR_RESET        = 8'h60;

    // modem_control_reg fields
    localparam int          MCR_DTR          = 0;
    localparam int          MCR_RTS          = 1;
    localparam int          MCR_RING         = 2;
    localparam int          MCR_IRQ_EN       = 3;
    localparam int          MCR_LOOP         = 4;
    localparam int          MCR_W            = 5;
    localparam logic [4:0]  MCR_RESET        = 5'h00;

    localparam int          ICR_TX_EMPTY_EN  = 1;
    localparam int          FCR_FIFO_EN      = 0;
    localparam logic        CTRL_BIT_RESET   = 1'b0;
endpackage : uart_lsm_pkg

// >>> tb/line_peer.sv
// Purpose: line side peer. Assumes: bench picks levels. Notes: the four modem pins active low, serial in not.
`timescale 1ns/1ns
`default_nettype none
module line_peer (
    input  wire logic       i_core_clk,
    input  wire logic [4:0] i_lvl,
    output var  logic [4:0] o_pins
);
    always_ff @(posedge i_core_clk) begin
        o_pins <= i_lvl;
    end
endmodule : line_peer
`default_nettype wire

// >>> tb/uart_line_status_modem_control_bench.sv
// Purpose: self-checking bench. Assumes: 25 MHz. Notes: table loop, then hand cases.
`timescale 1ns/1ns
`default_nettype none
module uart_line_status_modem_control_bench;
    import uart_lsm_pkg::*;
    typedef struct packed {logic [7:0] mcr; logic [3:0] pin_n; logic [3:0] pins; logic [3:0] view;} row_t;
    logic i_core_clk = 0, i_srst = 1, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
    logic i_s_axi_arvalid = 0, i_s_axi_rready = 0, i_rx_data_avail = 0, i_rx_err_in_fifo = 1, i_tx_load = 0;
    logic i_rx_stat_load = 0, i_rx_stat_brk = 0, i_rx_stat_frm = 0, i_rx_stat_par = 0, i_rx_overrun = 0;
    logic i_tx_fifo_empty = 1, i_tx_holding_empty = 1, i_tx_shift_empty = 1, i_tx_serial = 0, i_int_req = 1;
    logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0, o_tx_data;
    logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb = 4'hf;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic [4:0] lvl = 5'h1f;
    wire i_serial_in, i_cts_n, i_dsr_n, i_ri_n, i_dcd_n;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_serial_out;
    logic o_rts_n, o_dtr_n, o_rx_serial, o_cts, o_dsr, o_ri, o_dcd, o_fifo_mode, o_tx_wr, o_tx_empty_int, o_irq;
    int err_total = 0, n_compared = 0;
    row_t rows [5] = '{'{8'h03, 4'hf, 4'h0, 4'h0}, '{8'h08, 4'h0, 4'hd, 4'hf}, '{8'h1f, 4'h0, 4'hf, 4'hf},
                       '{8'h15, 4'h0, 4'hd, 4'h6}, '{8'h02, 4'he, 4'h4, 4'h1}};
    uart_lsm u_dut (.*);
    line_peer u_peer (.i_core_clk, .i_lvl(lvl), .o_pins({i_serial_in, i_dcd_n, i_ri_n, i_dsr_n, i_cts_n}));
    always #20 i_core_clk = ~i_core_clk;
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected value at %0t: %h not %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected response at %0t: %h not %h", $time, got, exp);
        end
    endtask : cmp_resp
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 1;
        w = 1;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= {24'h0, d};
        i_s_axi_awvalid <= 1;
        i_s_axi_wvalid <= 1;
        while (aw || w) begin
            @(posedge i_core_clk);
            if (o_s_axi_awready) aw = 0;
            if (o_s_axi_wready) w = 0;
            i_s_axi_awvalid <= aw;
            i_s_axi_wvalid <= w;
        end
        // hold bready off a cycle; bvalid rises at that same edge, so the slave never has to hold its answer
        @(posedge i_core_clk);
        i_s_axi_bready <= 1;
        do @(posedge i_core_clk); while (!o_s_axi_bvalid);
        cmp_resp(o_s_axi_bresp, er);
        i_s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1;
        do @(posedge i_core_clk); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 0;
        @(posedge i_core_clk);
        i_s_axi_rready <= 1;
        do @(posedge i_core_clk); while (!o_s_axi_rvalid);
        cmp_val(o_s_axi_rdata, {24'h0, d});
        cmp_resp(o_s_axi_rresp, er);
        i_s_axi_rready <= 0;
    endtask : rd
    task automatic end_sim;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge i_core_clk);
        err_total++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge i_core_clk);
        i_srst <= 0;
        @(posedge i_core_clk);
        foreach (rows[k]) begin
            lvl <= {1'b1, rows[k].pin_n};
            {i_int_req, i_tx_serial} <= {k != 1, k[0]};
            wr(OFS_MODEM_CTRL, rows[k].mcr, RESP_OKAY);
            rd(OFS_MODEM_VIEW, rows[k].view, RESP_OKAY);
            cmp_val({o_rts_n, o_dtr_n, o_irq, o_serial_out}, rows[k].pins);
        end
        i_srst <= 1;
        repeat (6) @(posedge i_core_clk);
        i_srst <= 0;
        @(posedge i_core_clk);
        rd(OFS_LINE_STATUS, LSR_RESET, RESP_OKAY);
        rd(OFS_MODEM_CTRL, 8'h00, RESP_OKAY);
        {i_rx_data_avail, i_rx_stat_load, i_rx_stat_brk, i_rx_stat_frm, i_rx_stat_par, i_rx_overrun} <= 6'h3b;
        @(posedge i_core_clk);
        {i_rx_stat_load, i_rx_overrun} <= 2'h0;
        @(posedge i_core_clk);
        rd(OFS_LINE_STATUS, 8'h77, RESP_OKAY);
        i_rx_data_avail <= 0;
        rd(OFS_LINE_STATUS, 8'h60, RESP_OKAY);
        wr(OFS_FIFO_CTRL, 8'h01, RESP_OKAY);
        rd(OFS_LINE_STATUS, 8'he0, RESP_OKAY);
        cmp_val(o_fifo_mode, 1);
        i_rx_err_in_fifo <= 0;
        rd(OFS_LINE_STATUS, 8'he0, RESP_OKAY);
        rd(OFS_LINE_STATUS, 8'h60, RESP_OKAY);
        {i_tx_fifo_empty, i_tx_shift_empty} <= 2'h0;
        wr(OFS_TX_DATA, 8'h5a, RESP_OKAY);
        rd(OFS_LINE_STATUS, 8'h00, RESP_OKAY);
        {i_tx_fifo_empty, i_tx_shift_empty} <= 2'h3;
        rd(OFS_LINE_STATUS, 8'h60, RESP_OKAY);
        wr(OFS_INT_CTRL, 8'h02, RESP_OKAY);
        wr(OFS_FIFO_CTRL, 8'h00, RESP_OKAY);
        wr(OFS_TX_DATA, 8'h33, RESP_OKAY);
        cmp_val({o_tx_wr, o_tx_data}, 9'h133);
        rd(OFS_LINE_STATUS, 8'h40, RESP_OKAY);
        cmp_val(o_tx_empty_int, 0);
        i_tx_load <= 1;
        @(posedge i_core_clk);
        i_tx_load <= 0;
        repeat (2) @(posedge i_core_clk);
        cmp_val(o_tx_empty_int, 1);
        wr(OFS_LINE_STATUS, 8'hff, RESP_SLVERR);
        wr(8'h18, 8'hff, RESP_SLVERR);
        rd(8'h1c, 8'h00, RESP_SLVERR);
        end_sim;
    end
endmodule : uart_line_status_modem_control_bench
`default_nettype wire

// >>> tb/uart_lsm_chk.sv
// Purpose: bus and pin checks. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ns
`default_nettype none
module uart_lsm_chk (
    input wire logic i_core_clk, i_srst, i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready,
    input wire logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready, o_s_axi_rvalid,
    input wire logic i_s_axi_rready, i_int_req, o_irq, i_serial_in, i_tx_serial, o_serial_out, o_rx_serial,
    input wire logic [31:0] o_s_axi_rdata
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    sequence both_taken; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready; endsequence
    sequence resp_due; !o_s_axi_awready ##1 o_s_axi_bvalid && !o_s_axi_awready; endsequence
    a_write_answer: assert property (both_taken |=> resp_due) else $error("write answer late");
    a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("no rdata");
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
        else $error("rdata dropped");
    a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid) else $error("bvalid dropped");
    a_ready_low: assert property ($fell(o_s_axi_bvalid) |-> !o_s_axi_awready) else $error("awready early");
    a_irq_gate: assert property (o_irq |-> $past(i_int_req)) else $error("irq without request");
    a_serial_out_forced: assert property (o_serial_out != $past(i_tx_serial) |-> o_serial_out)
        else $error("serial out wrong");
    a_rx_route: assert property (o_rx_serial != $past(i_serial_in) |-> o_rx_serial == $past(i_tx_serial))
        else $error("rx path wrong");
endmodule : uart_lsm_chk
bind uart_lsm uart_lsm_chk u_chk (.*);
`default_nettype wire
